// >>> nvcal_defs.vh
// nvcal_defs.vh: offsets, field positions, reset values and timing counts
// assumes it is included by its bare name from the calendar clock design
`ifndef NVCAL_DEFS_VH
`define NVCAL_DEFS_VH

`define NVCAL_ADDR_W        11
`define NVCAL_CLK_HZ        50000000
`define NVCAL_PROBE_HZ      512
`define NVCAL_OFS_CENTURY   11'h7f8
`define NVCAL_OFS_SECONDS   11'h7f9
`define NVCAL_OFS_MINUTES   11'h7fa
`define NVCAL_OFS_HOURS     11'h7fb
`define NVCAL_OFS_WEEKDAY   11'h7fc
`define NVCAL_OFS_DATE      11'h7fd
`define NVCAL_OFS_MONTH     11'h7fe
`define NVCAL_OFS_YEAR      11'h7ff
`define NVCAL_BIT_SET       7
`define NVCAL_BIT_HOLD      6
`define NVCAL_BIT_HALT      7
`define NVCAL_BIT_PROBE     6
`define NVCAL_BIT_HEALTH    7
`define NVCAL_TOH_NS        5
`define NVCAL_TWEZ_NS       25
`define NVCAL_TOH_CYC       ((`NVCAL_TOH_NS + 19) / 20)
`define NVCAL_TWEZ_CYC      ((`NVCAL_TWEZ_NS / 20) < 1 ? 1 : (`NVCAL_TWEZ_NS / 20))
`define NVCAL_RST_SEC       8'h00
`define NVCAL_RST_MIN       8'h00
`define NVCAL_RST_HOUR      8'h00
`define NVCAL_RST_WDAY      8'h01
`define NVCAL_RST_DATE      8'h01
`define NVCAL_RST_MONTH     8'h01
`define NVCAL_RST_YEAR      8'h00
`define NVCAL_RST_CENT      8'h20

`endif

// >>> nvcal_top.v
// nvcal_top.v: 2k x 8 static ram with a bcd calendar clock in the top eight bytes
// assumes bus pins are synchronous to clock; the bidirectional data pin is
// resolved outside from data_lines_out and data_lines_oe
// ram contents are not reset; only the clock bytes take reset values
// Summary of operation
// - Hold bit of century register set freezes the visible clock registers.
// - While held, visible registers keep snapshot; internal counters keep counting.
// - Hold bit cleared: all visible registers reload together within one second.
// - Set bit of century register halts visible updates so host can load time.
// - Set bit cleared: loaded values copy into counters, counting resumes from them.
// - Seconds MSB set stops the oscillator and all timekeeping; writable anytime.
// - Probe bit set and oscillator running: seconds LSB toggles at 512 Hz.
// - Sustained seconds read with probe set: data line zero follows the toggle.
// - Clock registers sit at top eight addresses, accessed like ram bytes.
// - All time fields kept as packed bcd within their documented ranges.
// - Month lengths and leap years handled automatically through year 2100.
// - Unassigned clock register bits act as plain read/write storage.
// - Read when chip select low, output gate low, store strobe high.
// - Data lines driven only while chip select and output gate are both low.
// - On address change during read, old data holds for the hold interval.
// - Write occurs while store strobe and chip select are both low.
// - Output gate low as strobe falls: read data first, float within float delay.
// - Below power-fail threshold chip select is forced inactive; timekeeping continues.
// - Host access disturbs the internal timekeeping countdown only through the set bit, which holds it at zero, and the halt bit, which stops it.
// - Cell health bit is read-only: one when battery good, zero when exhausted.
`timescale 1ns/1ps
`include "nvcal_defs.vh"

module nvcal_top #(
  parameter CLK_HZ   = `NVCAL_CLK_HZ,
  parameter RAM_WORDS = 2040
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [10:0] address_lines,
  input  wire        chip_select_n,
  input  wire        output_gate_n,
  input  wire        store_strobe_n,
  input  wire [7:0]  data_lines_in,
  input  wire        powerfail_threshold,
  input  wire        cell_health_bit,
  output reg  [7:0]  data_lines_out,
  output reg         data_lines_oe
);

  localparam [31:0] SEC_DIV   = CLK_HZ;
  localparam [31:0] PROBE_DIV = CLK_HZ / (2 * `NVCAL_PROBE_HZ);

  // buffer and counter index of each clock byte: the low three address bits
  localparam [2:0]  IX_CENT   = 3'h0;
  localparam [2:0]  IX_SEC    = 3'h1;
  localparam [2:0]  IX_MIN    = 3'h2;
  localparam [2:0]  IX_HOUR   = 3'h3;
  localparam [2:0]  IX_WDAY   = 3'h4;
  localparam [2:0]  IX_DATE   = 3'h5;
  localparam [2:0]  IX_MONTH  = 3'h6;
  localparam [2:0]  IX_YEAR   = 3'h7;

  // bcd increment with wrap: returns lo when v reaches hi
  function [7:0] bcd_inc;
    input [7:0] v;
    input [7:0] hi;
    input [7:0] lo;
    begin
      if (v >= hi)
        bcd_inc = lo;
      else if (v[3:0] == 4'h9)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // tens times ten plus units; only the leap test needs a binary year
  function [7:0] bcd2bin;
    input [7:0] v;
    begin
      bcd2bin = v[7:4] * 8'd10 + {4'h0, v[3:0]};
    end
  endfunction

  // month length; leap every fourth year, including 2000, holds through 2100
  function [7:0] month_len;
    input [7:0] mon;
    input [7:0] yr;
    reg   [7:0] yb;
    begin
      yb = bcd2bin(yr);
      case (mon)
        8'h02:   month_len = (yb[1:0] == 2'b00) ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
        default: month_len = 8'h31;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ram and visible clock bytes
  reg [7:0] ram_mem [0:RAM_WORDS-1];
  reg [7:0] vis_reg [0:7];
  reg [7:0] cnt_reg [0:7];   // internal counters, index = offset low bits
  reg [7:0] rd_data;
  reg [7:0] ram_q;
  integer   i;

  wire cs_active = ~chip_select_n & ~powerfail_threshold;
  wire is_clock  = (address_lines[10:3] == 8'hff);
  wire [2:0] ridx = address_lines[2:0];
  wire wr_active = cs_active & ~store_strobe_n;
  wire rd_mode   = cs_active & ~output_gate_n & store_strobe_n;

  // control bits live in the visible bytes, so they act the cycle after a write
  wire hold_bit  = vis_reg[IX_CENT][`NVCAL_BIT_HOLD];
  wire set_bit   = vis_reg[IX_CENT][`NVCAL_BIT_SET];
  wire halt_bit  = vis_reg[IX_SEC][`NVCAL_BIT_HALT];
  wire probe_bit = vis_reg[IX_WDAY][`NVCAL_BIT_PROBE];
  wire frozen    = hold_bit | set_bit;

  reg set_bit_d;

  // falling edge of the set bit is the moment the loaded bytes enter the counters
  always @(posedge clock) begin
    if (rst)
      set_bit_d <= 1'b0;
    else
      set_bit_d <= set_bit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-second tick and 512 hz probe, both stopped by the halt bit
  reg [31:0] sec_cnt_reg;
  reg [31:0] probe_cnt_reg;
  reg        probe_reg;
  wire       sec_tick = ~halt_bit & ~set_bit & (sec_cnt_reg == SEC_DIV - 32'd1);

  // second divider is held at zero while the set bit is up, so the first
  // second after a load is a whole one
  always @(posedge clock) begin
    if (rst) begin
      sec_cnt_reg <= 32'h0;
    end else if (halt_bit) begin
      sec_cnt_reg <= sec_cnt_reg;
    end else if (set_bit) begin
      sec_cnt_reg <= 32'h0;
    end else if (sec_cnt_reg == SEC_DIV - 32'd1) begin
      sec_cnt_reg <= 32'h0;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h1;
    end
  end

  // probe divider runs through hold and set; only the halt bit stops it
  always @(posedge clock) begin
    if (rst) begin
      probe_cnt_reg <= 32'h0;
      probe_reg     <= 1'b0;
    end else if (halt_bit) begin
      probe_cnt_reg <= probe_cnt_reg;
    end else if (probe_cnt_reg == PROBE_DIV - 32'd1) begin
      probe_cnt_reg <= 32'h0;
      probe_reg     <= ~probe_reg;
    end else begin
      probe_cnt_reg <= probe_cnt_reg + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters, visible buffer and host writes
  // a write lands every cycle the strobe is low; the final cycle's data wins
  // carry chain: a stage rolls over when every stage below it is at its top
  wire sec_wrap  = (cnt_reg[IX_SEC][6:0] == 7'h59);
  wire min_wrap  = sec_wrap & (cnt_reg[IX_MIN][6:0] == 7'h59);
  wire midnight  = min_wrap & (cnt_reg[IX_HOUR][5:0] == 6'h23);
  // the month spare bits are masked out, so storage bits cannot upset the length
  wire end_month = ({2'b00, cnt_reg[IX_DATE][5:0]} ==
                    month_len({3'b000, cnt_reg[IX_MONTH][4:0]}, cnt_reg[IX_YEAR]));
  wire end_year  = end_month & (cnt_reg[IX_MONTH][4:0] == 5'h12);
  wire end_cent  = end_year & (cnt_reg[IX_YEAR] == 8'h99);

  // next value of each field; the full byte is cut to the field it feeds
  wire [7:0] sec_next   = bcd_inc({1'b0, cnt_reg[IX_SEC][6:0]}, 8'h59, 8'h00);
  wire [7:0] min_next   = bcd_inc({1'b0, cnt_reg[IX_MIN][6:0]}, 8'h59, 8'h00);
  wire [7:0] hour_next  = bcd_inc({2'b00, cnt_reg[IX_HOUR][5:0]}, 8'h23, 8'h00);
  wire [7:0] date_next  = end_month ? 8'h01 :
                          bcd_inc({2'b00, cnt_reg[IX_DATE][5:0]}, 8'h31, 8'h01);
  wire [7:0] month_next = bcd_inc({3'b000, cnt_reg[IX_MONTH][4:0]}, 8'h12, 8'h01);
  wire [7:0] year_next  = bcd_inc(cnt_reg[IX_YEAR], 8'h99, 8'h00);
  wire [7:0] cent_next  = bcd_inc({2'b00, cnt_reg[IX_CENT][5:0]}, 8'h39, 8'h00);
  wire [2:0] wday_next  = (cnt_reg[IX_WDAY][2:0] == 3'h7) ? 3'h1 :
                          cnt_reg[IX_WDAY][2:0] + 3'h1;

  always @(posedge clock) begin
    if (rst) begin
      cnt_reg[0] <= `NVCAL_RST_CENT;
      cnt_reg[1] <= `NVCAL_RST_SEC;
      cnt_reg[2] <= `NVCAL_RST_MIN;
      cnt_reg[3] <= `NVCAL_RST_HOUR;
      cnt_reg[4] <= `NVCAL_RST_WDAY;
      cnt_reg[5] <= `NVCAL_RST_DATE;
      cnt_reg[6] <= `NVCAL_RST_MONTH;
      cnt_reg[7] <= `NVCAL_RST_YEAR;
      vis_reg[0] <= `NVCAL_RST_CENT;
      vis_reg[1] <= `NVCAL_RST_SEC;
      vis_reg[2] <= `NVCAL_RST_MIN;
      vis_reg[3] <= `NVCAL_RST_HOUR;
      vis_reg[4] <= `NVCAL_RST_WDAY;
      vis_reg[5] <= `NVCAL_RST_DATE;
      vis_reg[6] <= `NVCAL_RST_MONTH;
      vis_reg[7] <= `NVCAL_RST_YEAR;
    end else begin
      if (set_bit_d & ~set_bit) begin
        for (i = 0; i < 8; i = i + 1)
          cnt_reg[i] <= vis_reg[i];
      end else if (sec_tick) begin
        cnt_reg[IX_SEC][6:0] <= sec_next[6:0];
        if (sec_wrap)
          cnt_reg[IX_MIN][6:0] <= min_next[6:0];
        if (min_wrap)
          cnt_reg[IX_HOUR][5:0] <= hour_next[5:0];
        if (midnight) begin
          cnt_reg[IX_WDAY][2:0] <= wday_next;
          cnt_reg[IX_DATE][5:0] <= date_next[5:0];
          if (end_month)
            cnt_reg[IX_MONTH][4:0] <= month_next[4:0];
          if (end_year)
            cnt_reg[IX_YEAR] <= year_next;
          if (end_cent)
            cnt_reg[IX_CENT][5:0] <= cent_next[5:0];
        end
      end
      // refresh visible time fields together; spare and control bits stay host-owned
      if (~frozen) begin
        vis_reg[0][5:0] <= cnt_reg[0][5:0];
        vis_reg[1][6:0] <= cnt_reg[1][6:0];
        vis_reg[2][6:0] <= cnt_reg[2][6:0];
        vis_reg[3][5:0] <= cnt_reg[3][5:0];
        vis_reg[4][2:0] <= cnt_reg[4][2:0];
        vis_reg[5][5:0] <= cnt_reg[5][5:0];
        vis_reg[6][4:0] <= cnt_reg[6][4:0];
        vis_reg[7]      <= cnt_reg[7];
      end
      if (wr_active & is_clock)
        vis_reg[ridx] <= data_lines_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain ram below the clock bytes; a battery-backed array keeps its contents
  always @(posedge clock) begin
    if (wr_active & ~is_clock)
      ram_mem[address_lines] <= data_lines_in;
    ram_q <= ram_mem[address_lines];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and output enable
  reg [10:0] addr_d;
  reg [1:0]  wez_cnt_reg;
  // float delay in clock cycles, at least one; two bits hold any sane setting
  wire [31:0] wez_full = `NVCAL_TWEZ_CYC;
  wire [1:0]  wez_cyc  = wez_full[1:0];
  wire        addr_same = (addr_d == address_lines);
  reg [7:0]  clk_byte;

  always @* begin
    clk_byte = vis_reg[ridx];
    // health pin replaces the stored bit on every read; writes to it stay unseen
    if (ridx == IX_WDAY)
      clk_byte[`NVCAL_BIT_HEALTH] = cell_health_bit;
    if ((ridx == IX_SEC) & probe_bit & ~halt_bit)
      clk_byte[0] = probe_reg;
  end

  always @(posedge clock) begin
    if (rst) begin
      data_lines_out <= 8'h00;
      data_lines_oe  <= 1'b0;
      addr_d         <= 11'h000;
      wez_cnt_reg    <= 2'd0;
    end else begin
      addr_d <= address_lines;
      // old data stands one more cycle after an address change
      if (rd_mode & addr_same)
        data_lines_out <= is_clock ? clk_byte : ram_q;
      if (~cs_active | output_gate_n) begin
        data_lines_oe <= 1'b0;
        wez_cnt_reg   <= 2'd0;
      end else if (~store_strobe_n) begin
        // gate already low as the strobe falls: pins float after the float delay
        if (wez_cnt_reg >= wez_cyc - 2'd1)
          data_lines_oe <= 1'b0;
        else
          wez_cnt_reg <= wez_cnt_reg + 2'd1;
      end else begin
        data_lines_oe <= 1'b1;
        wez_cnt_reg   <= 2'd0;
      end
    end
  end

endmodule

// >>> nvcal_checker.sv
// nvcal_checker.sv: bus and clock-byte checks on the calendar ram pins
// assumes CLK_HZ is set so the probe square toggles every two cycles
`timescale 1ns/1ps
module nvcal_checker #(
  parameter CLK_HZ = 2048
) (
  input wire        clock,
  input wire        rst,
  input wire [10:0] address_lines,
  input wire        chip_select_n,
  input wire        output_gate_n,
  input wire        store_strobe_n,
  input wire [7:0]  data_lines_in,
  input wire        powerfail_threshold,
  input wire        cell_health_bit,
  input wire [7:0]  data_lines_out,
  input wire        data_lines_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire rd = !chip_select_n && !output_gate_n && store_strobe_n && !powerfail_threshold;
  wire wr = !chip_select_n && !store_strobe_n && !powerfail_threshold;
  reg  probe_reg;
  reg  halt_reg;
  ////////////////////////////////////////
  // mirror of probe and halt bits, so the rate check only runs when it applies
  always @(posedge clock) begin
    if (rst) begin
      probe_reg <= 1'b0;
      halt_reg  <= 1'b0;
    end else if (wr && address_lines == 11'h7fc) begin
      probe_reg <= data_lines_in[6];
    end else if (wr && address_lines == 11'h7f9) begin
      halt_reg <= data_lines_in[7];
    end
  end
  ////////////////////////////////////////
  chk_read_drives: assert property (rd |=> data_lines_oe)
    else $error("read cycle left the data lines floating");
  chk_drive_cause: assert property (data_lines_oe |-> $past(!chip_select_n && !output_gate_n))
    else $error("data lines driven without select and gate");
  chk_bus_release: assert property ((chip_select_n || output_gate_n) |=> !data_lines_oe)
    else $error("data lines not released");
  chk_powerfail_block: assert property (powerfail_threshold |=> !data_lines_oe)
    else $error("access not blocked below threshold");
  chk_write_float: assert property ((!chip_select_n && !store_strobe_n) |=> !data_lines_oe)
    else $error("outputs still driven during write");
  chk_addr_hold: assert property (((rd && data_lines_oe && $stable(address_lines)) [*2]
    ##1 (rd && $changed(address_lines))) |=> $stable(data_lines_out))
    else $error("old data not held after address change");
  chk_health_read: assert property ((rd && address_lines == 11'h7fc) [*3]
    |-> data_lines_out[7] == cell_health_bit)
    else $error("health bit does not follow its pin");
  chk_probe_rate: assert property ((rd && address_lines == 11'h7f9 && probe_reg && !halt_reg) [*5]
    |-> data_lines_out[0] != $past(data_lines_out[0], 2))
    else $error("probe square not at the expected rate");
endmodule

// >>> nvcal_host_model.sv
// nvcal_host_model.sv: host side of the shared bytewide data bus
// assumes the host drives only while the device has released the bus
`timescale 1ns/1ps
module nvcal_host_model (
  input  wire       clock,
  input  wire [7:0] data_lines_out,
  input  wire       data_lines_oe,
  input  wire [7:0] host_data,
  input  wire       host_drive,
  output wire [7:0] data_bus
);
  reg [7:0] last_reg = 8'h00;
  // no pull on the bus: an idle bus flips every cycle, never a stale copy
  assign data_bus = data_lines_oe ? data_lines_out : (host_drive ? host_data : ~last_reg);
  always @(posedge clock) begin
    last_reg <= data_bus;
  end
endmodule

// >>> nvcal_top_bench.sv
// nvcal_top_bench.sv: directed bus tests of the calendar ram
// assumes CLK_HZ of 2048, so one second is 2048 cycles of 20 ns
`timescale 1ns/1ps
module nvcal_top_bench;
  localparam [63:0] RV = 64'h2000_0000_8101_0100;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg  [10:0] address_lines = 11'h000;
  reg         chip_select_n = 1'b1;
  reg         output_gate_n = 1'b1;
  reg         store_strobe_n = 1'b1;
  reg         powerfail_threshold = 1'b0;
  reg         cell_health_bit = 1'b1;
  reg  [7:0]  host_data = 8'h00;
  reg         host_drive = 1'b0;
  reg  [7:0]  rdv;
  wire [7:0]  data_bus;
  wire [7:0]  data_lines_out;
  wire        data_lines_oe;
  integer     n_mismatch = 0;
  integer     tests_run = 0;
  integer     i;
  integer     n_tog;
  always #10 clock = ~clock;
  nvcal_top #(.CLK_HZ(2048)) uut (.clock(clock), .rst(rst), .address_lines(address_lines),
    .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
    .store_strobe_n(store_strobe_n), .data_lines_in(data_bus),
    .powerfail_threshold(powerfail_threshold), .cell_health_bit(cell_health_bit),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
  nvcal_host_model host (.clock(clock), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .host_data(host_data), .host_drive(host_drive),
    .data_bus(data_bus));
  ////////////////////////////////////////
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [10:0] a, input [7:0] e, input [7:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value byte %h expected %h seen %h", a, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask
  // address and data stay put until the strobe is back high
  task wr(input [10:0] a, input [7:0] d);
    begin
      @(negedge clock);
      address_lines = a;
      host_data = d;
      host_drive = 1'b1;
      chip_select_n = 1'b0;
      store_strobe_n = 1'b0;
      @(negedge clock);
      chip_select_n = 1'b1;
      store_strobe_n = 1'b1;
      @(negedge clock);
      host_drive = 1'b0;
    end
  endtask
  task rdck(input [10:0] a, input [7:0] e);
    integer n;
    begin
      @(negedge clock);
      address_lines = a;
      chip_select_n = 1'b0;
      output_gate_n = 1'b0;
      n = 0;
      while (data_lines_oe !== 1'b1 && n < 8) begin
        @(negedge clock);
        n = n + 1;
      end
      @(negedge clock);
      rdv = data_bus;
      chip_select_n = 1'b1;
      output_gate_n = 1'b1;
      if (n == 8) begin
        n_mismatch = n_mismatch + 1;
        finish_test;
      end else begin
        chk(a, e, rdv);
      end
    end
  endtask
  task set_time(input [7:0] y, input [7:0] mo, input [7:0] emo, input [7:0] ed);
    reg [63:0] v;
    reg [47:0] x;
    begin
      v = {8'ha0, 8'h59, 8'h59, 8'h23, 8'h27, 8'h28, mo, y};
      x = {8'h00, 8'h00, 8'ha1, ed, emo, y};
      for (i = 0; i < 8; i = i + 1)
        wr(11'h7f8 + i[10:0], v[63 - 8 * i -: 8]);
      wr(11'h7f8, 8'h20);
      cyc(3000);
      for (i = 0; i < 6; i = i + 1)
        rdck(11'h7fa + i[10:0], x[47 - 8 * i -: 8]);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      rdck(11'h7f8 + i[10:0], RV[63 - 8 * i -: 8]);
    $display("test reset values done");
    wr(11'h000, 8'ha5);
    wr(11'h7f7, 8'h3c);
    output_gate_n = 1'b0;
    wr(11'h010, 8'h96);
    output_gate_n = 1'b1;
    rdck(11'h000, 8'ha5);
    rdck(11'h010, 8'h96);
    @(negedge clock);
    chip_select_n = 1'b0;
    output_gate_n = 1'b0;
    cyc(3);
    address_lines = 11'h7f7;
    cyc(3);
    chk(11'h7f7, 8'h3c, data_bus);
    chip_select_n = 1'b1;
    output_gate_n = 1'b1;
    powerfail_threshold = 1'b1;
    wr(11'h000, 8'hff);
    chip_select_n = 1'b0;
    output_gate_n = 1'b0;
    cyc(3);
    chk(11'h000, 8'h00, {7'h00, data_lines_oe});
    chip_select_n = 1'b1;
    output_gate_n = 1'b1;
    powerfail_threshold = 1'b0;
    rdck(11'h000, 8'ha5);
    $display("test ram done");
    set_time(8'h23, 8'h82, 8'h83, 8'h01);
    set_time(8'h24, 8'h02, 8'h02, 8'h29);
    $display("test calendar done");
    wr(11'h7f8, 8'ha0);
    wr(11'h7f9, 8'h80);
    wr(11'h7f8, 8'h20);
    cyc(2500);
    rdck(11'h7f9, 8'h80);
    wr(11'h7f8, 8'ha0);
    wr(11'h7f9, 8'h00);
    wr(11'h7f8, 8'h20);
    wr(11'h7f8, 8'h60);
    cyc(2100);
    rdck(11'h7f9, 8'h00);
    wr(11'h7f8, 8'h20);
    rdck(11'h7f9, 8'h01);
    chk(11'h7f9, 8'h01, rdv - {7'h00, rdv == 8'h02});
    $display("test freeze done");
    wr(11'h7fc, 8'h41);
    @(negedge clock);
    address_lines = 11'h7f9;
    chip_select_n = 1'b0;
    output_gate_n = 1'b0;
    cyc(3);
    n_tog = 0;
    for (i = 0; i < 16; i = i + 1) begin
      rdv = data_bus;
      @(negedge clock);
      if (data_bus[0] !== rdv[0])
        n_tog = n_tog + 1;
    end
    chk(11'h7f9, 8'h08, n_tog[7:0]);
    chip_select_n = 1'b1;
    output_gate_n = 1'b1;
    $display("test probe done");
    cell_health_bit = 1'b0;
    wr(11'h7fc, 8'hc1);
    rdck(11'h7fc, 8'h41);
    $display("test health done");
    finish_test;
  end
endmodule
bind nvcal_top nvcal_checker #(.CLK_HZ(CLK_HZ)) u_chk (.clock(clock), .rst(rst),
  .address_lines(address_lines), .chip_select_n(chip_select_n),
  .output_gate_n(output_gate_n), .store_strobe_n(store_strobe_n),
  .data_lines_in(data_lines_in), .powerfail_threshold(powerfail_threshold),
  .cell_health_bit(cell_health_bit), .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe));
